// ### hw/trip_sup_pkg.sv
// constants and types shared by the trip path supervision design
package trip_sup_pkg;
    // clock rate and millisecond tick
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TICK_MS_US = 1000;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_MS_US;
    localparam int unsigned TICK_CNT_W = 15;
    // pick-up delay
    localparam int unsigned PICKUP_MS = 1000;
    localparam int unsigned PICKUP_CNT_W = 10;
    // apb register map
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    // status register fields
    localparam int unsigned ST_SUP_A_BIT = 0;
    localparam int unsigned ST_SUP_B_BIT = 1;
    localparam int unsigned ST_FAULT_A_BIT = 2;
    localparam int unsigned ST_FAULT_B_BIT = 3;
    localparam int unsigned ST_CLOSED_BIT = 4;
    // irq status/mask fields: fault rise per channel
    localparam int unsigned IRQ_FAULT_A_BIT = 0;
    localparam int unsigned IRQ_FAULT_B_BIT = 1;
    localparam int unsigned IRQ_W = 2;
    // control fields: per-channel enable
    localparam int unsigned CTRL_EN_A_BIT = 0;
    localparam int unsigned CTRL_EN_B_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam int unsigned NUM_CH = 2;
endpackage

// ### hw/trip_sup_ch_if.sv
// channel bundle between top and the supervision channels
`timescale 1ns/1ps
`default_nettype none
interface trip_sup_ch_if;
    logic [1:0] sup;
    logic qualify;
    logic [1:0] enable;
    logic tick;
    logic [1:0] fault;
    modport top (output sup, output qualify, output enable, output tick, input fault);
    modport chan (input sup, input qualify, input enable, input tick, output fault);
endinterface
`default_nettype wire

// ### hw/trip_sup_channels.sv
// two pick-up delay channels for trip path supervision
`timescale 1ns/1ps
`default_nettype none
module trip_sup_channels
    import trip_sup_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // channel bundle
    trip_sup_ch_if.chan ch
);
    typedef struct packed {
        logic [NUM_CH-1:0][PICKUP_CNT_W-1:0] cnt;
        logic [NUM_CH-1:0] fault;
    } ch_state_s;

    ch_state_s state_ff;
    ch_state_s nxt_state;

    assign ch.fault = state_ff.fault;

    // per channel: low input while closed counts ticks; no cross-coupling
    always_comb
    begin
        nxt_state = state_ff;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!(ch.qualify && ch.enable[i] && !ch.sup[i]))
            begin
                nxt_state.cnt[i] = '0;
                nxt_state.fault[i] = 1'b0;
            end
            else if (ch.tick && !state_ff.fault[i])
            begin
                if (state_ff.cnt[i] == PICKUP_CNT_W'(PICKUP_MS - 1))
                begin
                    nxt_state.fault[i] = 1'b1;
                end
                else
                begin
                    nxt_state.cnt[i] = state_ff.cnt[i] + PICKUP_CNT_W'(1);
                end
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end
endmodule // trip_sup_channels
`default_nettype wire

// ### hw/trip_path_supervision.sv
// trip path supervision top: breaker qualification, ms tick, apb registers, irq
//
// How it works
// - a high supervision input means the trip circuit is intact, low means broken or too resistive.
// - each supervision input is also shown as a plain status bit and a registered output.
// - failure is judged only while the breaker reads closed, never while it is open.
// - two independent channels share one pair of breaker status inputs, each with its own fault output.
// - a fault asserts only after the qualified condition held without break for 1000 ms.
// - fault outputs are active high, the inverse of the supervision input.
// - fault a follows input a and fault b follows input b, no cross-coupling.
`timescale 1ns/1ps
`default_nettype none
module trip_path_supervision
    import trip_sup_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // supervision and breaker status inputs
    input wire logic trip_sup_in_a_in,
    input wire logic trip_sup_in_b_in,
    input wire logic breaker_open_status_in,
    input wire logic breaker_closed_status_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // supervision results
    output logic circuit_fault_a_out,
    output logic circuit_fault_b_out,
    output logic trip_sup_a_out,
    output logic trip_sup_b_out,
    output logic irq_out
);
    typedef struct packed {
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic tick;
        logic [1:0] fault_q;
        logic [1:0] sup_q;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [1:0] ctrl_en;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } top_state_s;

    top_state_s state_ff;
    top_state_s nxt_state;
    trip_sup_ch_if ch_bus ();

    // true when the apb access phase hits the given word
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction

    // channel inputs; active-high supervision input means intact
    assign ch_bus.sup = {trip_sup_in_b_in, trip_sup_in_a_in};
    assign ch_bus.qualify = breaker_closed_status_in && !breaker_open_status_in;
    assign ch_bus.enable = state_ff.ctrl_en;
    assign ch_bus.tick = state_ff.tick;

    // shared channel pair, one fault line each
    trip_sup_channels u_channels (
        .sys_clk_in (sys_clk_in),
        .rst_in (rst_in),
        .ch (ch_bus.chan)
    );

    // next state: tick divider, irq capture, apb access
    always_comb
    begin
        logic access;
        logic [IRQ_W-1:0] rise;
        logic [IRQ_W-1:0] clr;
        access = 1'b0;
        rise = '0;
        clr = '0;
        nxt_state = state_ff;

        // ms time base drives the pick-up delay
        if (state_ff.tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1))
        begin
            nxt_state.tick_cnt = '0;
            nxt_state.tick = 1'b1;
        end
        else
        begin
            nxt_state.tick_cnt = state_ff.tick_cnt + TICK_CNT_W'(1);
            nxt_state.tick = 1'b0;
        end

        // outputs registered one cycle behind the channels
        nxt_state.fault_q = ch_bus.fault;
        nxt_state.sup_q = ch_bus.sup;
        rise = ch_bus.fault & ~state_ff.fault_q;

        // apb: ready registered in the cycle after the first access cycle, one wait state
        nxt_state.pready = 1'b0;
        nxt_state.pslverr = 1'b0;
        access = psel_in && penable_in && !state_ff.pready;
        if (access)
        begin
            nxt_state.pready = 1'b1;
            nxt_state.prdata = '0;
            if (pwrite_in)
            begin
                if (hit(paddr_in, ADDR_IRQ_STAT))
                begin
                    clr = pwdata_in[IRQ_W-1:0];
                end
                else if (hit(paddr_in, ADDR_IRQ_MASK))
                begin
                    nxt_state.irq_mask = pwdata_in[IRQ_W-1:0];
                end
                else if (hit(paddr_in, ADDR_CTRL))
                begin
                    nxt_state.ctrl_en = pwdata_in[1:0];
                end
                else if (!hit(paddr_in, ADDR_STATUS))
                begin
                    nxt_state.pslverr = 1'b1;
                end
            end
            else
            begin
                if (hit(paddr_in, ADDR_STATUS))
                begin
                    nxt_state.prdata[ST_SUP_A_BIT] = state_ff.sup_q[0];
                    nxt_state.prdata[ST_SUP_B_BIT] = state_ff.sup_q[1];
                    nxt_state.prdata[ST_FAULT_A_BIT] = state_ff.fault_q[0];
                    nxt_state.prdata[ST_FAULT_B_BIT] = state_ff.fault_q[1];
                    nxt_state.prdata[ST_CLOSED_BIT] = ch_bus.qualify;
                end
                else if (hit(paddr_in, ADDR_IRQ_STAT))
                begin
                    nxt_state.prdata[IRQ_W-1:0] = state_ff.irq_stat;
                end
                else if (hit(paddr_in, ADDR_IRQ_MASK))
                begin
                    nxt_state.prdata[IRQ_W-1:0] = state_ff.irq_mask;
                end
                else if (hit(paddr_in, ADDR_CTRL))
                begin
                    nxt_state.prdata[1:0] = state_ff.ctrl_en;
                end
                else
                begin
                    nxt_state.pslverr = 1'b1;
                end
            end
        end

        // set beats clear so an edge in the clearing cycle is kept
        nxt_state.irq_stat = (state_ff.irq_stat & ~clr) | rise;
        nxt_state.irq = |(nxt_state.irq_stat & nxt_state.irq_mask);
    end

    // state register
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state_ff <= '0;
            state_ff.irq_mask <= MASK_RESET;
            state_ff.ctrl_en <= CTRL_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // all outputs straight from flops
    assign prdata_out = state_ff.prdata;
    assign pready_out = state_ff.pready;
    assign pslverr_out = state_ff.pslverr;
    assign circuit_fault_a_out = state_ff.fault_q[0];
    assign circuit_fault_b_out = state_ff.fault_q[1];
    assign trip_sup_a_out = state_ff.sup_q[0];
    assign trip_sup_b_out = state_ff.sup_q[1];
    assign irq_out = state_ff.irq;
endmodule // trip_path_supervision
`default_nettype wire

// ### sim/trip_field_model.sv
// breaker contacts and trip circuit opto inputs seen by the device
`timescale 1ns/1ps
`default_nettype none
module trip_field_model
(
    // scenario controls
    input wire logic intact_a_in,
    input wire logic intact_b_in,
    input wire logic closed_in,
    input wire logic disagree_in,
    input wire logic single_in,
    // pins toward the device
    output logic sup_a_out,
    output logic sup_b_out,
    output logic open_st_out,
    output logic closed_st_out
);
    // intact circuit carries test current, opto reads high
    assign sup_a_out = intact_a_in;
    // one trip circuit: second input left open reads low
    assign sup_b_out = intact_b_in && !single_in;
    // disagree flips the open contact to give both or neither
    assign closed_st_out = closed_in;
    assign open_st_out = !closed_in ^ disagree_in;
endmodule // trip_field_model
`default_nettype wire

// ### sim/trip_sup_assertions.sv
// port checker for the trip path supervision top
`timescale 1ns/1ps
`default_nettype none
module trip_sup_checker
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // field inputs
    input wire logic trip_sup_in_a_in,
    input wire logic trip_sup_in_b_in,
    input wire logic breaker_open_status_in,
    input wire logic breaker_closed_status_in,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // results
    input wire logic circuit_fault_a_out,
    input wire logic circuit_fault_b_out,
    input wire logic trip_sup_a_out,
    input wire logic trip_sup_b_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic qual_a;
    logic qual_b;
    logic [24:0] run_a_ff;
    // breaker closed and circuit reads broken
    assign qual_a = breaker_closed_status_in && !breaker_open_status_in && !trip_sup_in_a_in;
    assign qual_b = breaker_closed_status_in && !breaker_open_status_in && !trip_sup_in_b_in;
    // saturating run length, too long for a repetition count
    always_ff @(posedge sys_clk_in)
    begin
        run_a_ff <= (rst_in || !qual_a) ? 25'h0 : run_a_ff + {24'h0, run_a_ff != 25'h1FFFFFF};
    end
    a_fault_a_delay: assert property ($rose(circuit_fault_a_out) |-> run_a_ff >= 25'h130DAF8)
        else $error("fault a rose early");
    a_fault_a_idle: assert property (!qual_a [*4] |-> !circuit_fault_a_out)
        else $error("fault a without cause");
    a_fault_b_idle: assert property (!qual_b [*4] |-> !circuit_fault_b_out)
        else $error("fault b without cause");
    a_sup_a_copy: assert property (!$past(rst_in) |-> trip_sup_a_out == $past(trip_sup_in_a_in))
        else $error("sup a copy wrong");
    a_sup_b_copy: assert property (!$past(rst_in) |-> trip_sup_b_out == $past(trip_sup_in_b_in))
        else $error("sup b copy wrong");
    a_apb_answer: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("no apb answer");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready too long");
    a_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    // main scenarios reached
    cover property (pready_out && pslverr_out);
    cover property (qual_a [*8]);
    cover property (!qual_b [*4]);
endmodule // trip_sup_checker
bind trip_path_supervision trip_sup_checker trip_sup_checker_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .trip_sup_in_a_in(trip_sup_in_a_in), .trip_sup_in_b_in(trip_sup_in_b_in),
    .breaker_open_status_in(breaker_open_status_in), .breaker_closed_status_in(breaker_closed_status_in),
    .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .circuit_fault_a_out(circuit_fault_a_out), .circuit_fault_b_out(circuit_fault_b_out),
    .trip_sup_a_out(trip_sup_a_out), .trip_sup_b_out(trip_sup_b_out));
`default_nettype wire

// ### sim/tb.sv
// register and field tests of the trip path supervision top
`timescale 1ns/1ps
`default_nettype none
module tb;
    import trip_sup_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic [31:0] prdata;
    logic ia = 1'b1;
    logic ib = 1'b0;
    logic cl = 1'b0;
    logic dis = 1'b0;
    logic sg = 1'b0;
    logic err, sa, sb, os, cs, pready, pslverr, fa, fb, soa, sob, irq;
    int fail_count = 0;
    int n_tests = 0;
    // 20 MHz clock
    always #25 clk = ~clk;
    trip_field_model trip_field_model_i (.intact_a_in(ia), .intact_b_in(ib), .closed_in(cl), .disagree_in(dis),
        .single_in(sg), .sup_a_out(sa), .sup_b_out(sb), .open_st_out(os), .closed_st_out(cs));
    trip_path_supervision trip_path_supervision_i (.sys_clk_in(clk), .rst_in(rst), .trip_sup_in_a_in(sa),
        .trip_sup_in_b_in(sb), .breaker_open_status_in(os), .breaker_closed_status_in(cs), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .circuit_fault_a_out(fa), .circuit_fault_b_out(fb),
        .trip_sup_a_out(soa), .trip_sup_b_out(sob), .irq_out(irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the watchdog bounds the wait for ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog well beyond the planned run
    initial
    begin
        repeat (90000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, {30'h0, CTRL_RESET});
        apb(1'b0, ADDR_IRQ_MASK, 32'h0);
        check(rd, {30'h0, MASK_RESET});
        apb(1'b0, 8'h10, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h3);
        apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
        apb(1'b0, ADDR_IRQ_MASK, 32'h0);
        check(rd, 32'h3);
        // unmapped write is refused with an error, nothing captured yet
        apb(1'b1, 8'h10, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check(rd, 32'h0);
        // enables read back, then restored so both channels run
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, ADDR_CTRL, {30'h0, CTRL_RESET});
        // all four contact combinations; a intact, b broken
        for (int k = 0; k < 4; k++)
        begin
            cl <= k[0];
            dis <= k[1];
            repeat (4) @(posedge clk);
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(rd, {27'h0, k == 1, 4'h1});
        end
        check({30'h0, soa, sob}, 32'h2);
        // closed with both circuits broken, well short of pick-up
        cl <= 1'b1;
        dis <= 1'b0;
        ia <= 1'b0;
        repeat (60000) @(posedge clk);
        check({29'h0, fa, fb, irq}, 32'h0);
        sg <= 1'b1;
        ib <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h10);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
